/* File: src/gns_net_gen.sv */
// growing dashed net symbol generator, single video clock
`timescale 1ns/1ps

// What this block does
// - serve rise clears return-pair counter
// - pair count zero loads 0001 in top half
// - bottom half: count up per dash-bit rise
// - net enable held off before terminal count
// - terminal count in bottom half stops, releases
// - enable sets on fine-bit rise, left half
// - enabled right half drives dashed low video
// - active-low presence indicator while net drawn
// - draw to field end, then reload
// - reload presets enable, ending net video
// - serve plus motion fires one-shot, sets pair-ff
// - return clears pair-ff, counter increments
// - top half presets from return-pair count
// - count 0101 holds pair-ff cleared
module gns_net_gen
    import gns_pkg::*;
#(
    parameter logic [3:0] SHOT_LEN = GNS_SHOT_LEN  // one-shot low time in cycles
)(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // beam position from timing counters
    input  wire gns_timing_t  timing,
    // serve and ball play signals
    input  wire gns_play_t    play,
    // net video and presence
    output      gns_net_out_t net_out,
    // current height step, for observation
    output      logic [3:0]   return_pair_count
);

    // ==========================================================
    // helpers

    // rising edge seen between two samples
    function automatic logic rose(input logic cur, input logic prev);
        rose = cur & ~prev;
    endfunction

    // start preset grows two steps per return pair
    function automatic logic [3:0] start_preset(input logic [3:0] pairs);
        start_preset = GNS_START_BASE + {pairs[2:0], 1'b0};
    endfunction

    // ==========================================================
    // state
    gns_state_t st_r;      // registered state
    gns_state_t st_nxt;    // next state
    logic       serve_up;  // serve rising this cycle
    logic       dash_up;   // dash bit rising
    logic       fine_up;   // fine bit rising
    logic       motion_up; // ball motion rising
    logic       return_up; // ball return rising
    logic       at_term;   // start counter finished
    logic       draw;      // net column region enabled

    // edge detection against the previous sample
    always_comb
    begin
        serve_up  = rose(play.serve, st_r.play_prev.serve);
        dash_up   = rose(timing.vert_dash_bit, st_r.tim_prev.vert_dash_bit);
        fine_up   = rose(timing.horiz_fine_bit, st_r.tim_prev.horiz_fine_bit);
        motion_up = rose(play.ball_motion, st_r.play_prev.ball_motion);
        return_up = rose(play.ball_return, st_r.play_prev.ball_return);
        at_term   = (st_r.divider_start_counter == GNS_START_TERM);
        draw      = st_r.divider_enable_ff & timing.horiz_half_bit;
    end

    // ==========================================================
    // next-state logic
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.tim_prev  = timing;
        st_nxt.play_prev = play;

        // net-start counter and enable flip-flop
        if (!timing.vert_half_bit)
        begin
            // top half: reload from pair count and hold net off
            st_nxt.divider_start_counter = start_preset(st_r.return_pair_counter);
            st_nxt.divider_enable_ff     = 1'b0;
        end
        else if (!at_term)
        begin
            // bottom half, still counting dash pulses
            if (dash_up)
                st_nxt.divider_start_counter = st_r.divider_start_counter + 4'h1;
            st_nxt.divider_enable_ff = 1'b0;
        end
        else if (fine_up && !timing.horiz_half_bit)
        begin
            // stopped at terminal, hold released; left half start
            st_nxt.divider_enable_ff = 1'b1;
        end

        // registered net outputs; enable stays until reload, so drawing runs to field end
        st_nxt.out.net_video_n   = ~(draw & timing.vert_dash_bit);
        st_nxt.out.net_present_n = ~draw;

        // return one-shot: countdown, trailing edge sets pair-ff
        if (st_r.return_oneshot != GNS_SHOT_IDLE)
        begin
            st_nxt.return_oneshot = st_r.return_oneshot - 4'h1;
            if (st_r.return_oneshot == 4'h1 && !st_r.return_pair_ff)
                st_nxt.return_pair_ff = 1'b1;
        end
        else if (play.serve && motion_up)
        begin
            st_nxt.return_oneshot = SHOT_LEN;
        end

        // next return ends the pair and bumps the counter
        if (return_up && st_r.return_pair_ff)
        begin
            st_nxt.return_pair_ff      = 1'b0;
            st_nxt.return_pair_counter = st_r.return_pair_counter + 4'h1;
        end

        // at maximum height the pair-ff is pinned clear
        if (st_nxt.return_pair_counter == GNS_PAIR_MAX)
            st_nxt.return_pair_ff = 1'b0;

        // a new serve restores minimum height; wins over a same-cycle increment
        if (serve_up)
        begin
            st_nxt.return_pair_counter = GNS_PAIR_ZERO;
            st_nxt.return_pair_ff      = 1'b0;
        end
    end

    // ==========================================================
    // state register, synchronous reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            st_r <= GNS_STATE_RESET;
        else
            st_r <= st_nxt;
    end

    // outputs straight from flip-flops
    assign net_out           = st_r.out;
    assign return_pair_count = st_r.return_pair_counter;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // pair completed: ff set and a return arrives
    sequence s_pair_done;
        st_r.return_pair_ff && return_up && !serve_up;
    endsequence

    // one-shot fired by serve and motion
    sequence s_shot_fire;
        (st_r.return_oneshot == GNS_SHOT_IDLE) && play.serve && motion_up;
    endsequence

    chk_serve_clears: assert property (serve_up |=> return_pair_count == 4'h0)
        else $error("serve did not clear return-pair counter");
    chk_zero_load: assert property
        ((st_r.return_pair_counter == 4'h0) && !timing.vert_half_bit
            |=> st_r.divider_start_counter == 4'h1)
        else $error("zero pair count did not load one");
    chk_count_step: assert property
        (timing.vert_half_bit && !at_term && dash_up
            |=> st_r.divider_start_counter == $past(st_r.divider_start_counter) + 4'h1)
        else $error("start counter did not step on dash bit");
    chk_hold_preset: assert property (!at_term |=> !st_r.divider_enable_ff)
        else $error("net enabled before terminal count");
    chk_stop_terminal: assert property
        (at_term && timing.vert_half_bit |=> st_r.divider_start_counter == 4'hF)
        else $error("start counter moved past terminal");
    chk_enable_set: assert property
        (at_term && timing.vert_half_bit && fine_up && !timing.horiz_half_bit
            |=> st_r.divider_enable_ff)
        else $error("net enable not set on fine bit");
    chk_video_gate: assert property
        (st_r.divider_enable_ff && timing.horiz_half_bit && timing.vert_dash_bit
            |=> !net_out.net_video_n)
        else $error("net video missing");
    chk_video_idle: assert property (!st_r.divider_enable_ff |=> net_out.net_video_n)
        else $error("net video without enable");
    chk_presence: assert property
        (1'b1 |=> net_out.net_present_n == !$past(draw))
        else $error("presence not inverse of net gating");
    chk_reload_preset: assert property
        (!timing.vert_half_bit
            |=> !st_r.divider_enable_ff ##1 (net_out.net_video_n && net_out.net_present_n))
        else $error("reload did not end net");
    // the reload in the top half is the only thing that may end the net
    chk_field_draw: assert property
        (timing.vert_field_end && timing.vert_half_bit && st_r.divider_enable_ff
            |=> st_r.divider_enable_ff)
        else $error("net ended before field end");
    chk_preset_map: assert property
        (!timing.vert_half_bit
            |=> st_r.divider_start_counter == 4'h1 + {$past(st_r.return_pair_counter[2:0]), 1'b0})
        else $error("preset not from pair count");
    chk_shot_set: assert property
        (s_shot_fire ##1 (!serve_up && !return_up)[*4] |=> st_r.return_pair_ff
            || st_r.return_pair_counter == 4'h5 || $past(st_r.return_pair_ff))
        else $error("one-shot trailing edge did not set pair-ff");
    chk_shot_load: assert property
        (s_shot_fire |=> st_r.return_oneshot == SHOT_LEN)
        else $error("one-shot not started by serve and motion");
    // holds for any one-shot length, unlike the fixed repetition above
    chk_shot_trail: assert property
        ((st_r.return_oneshot == 4'h1) && !st_r.return_pair_ff && !serve_up
            && (st_r.return_pair_counter != GNS_PAIR_MAX)
            |=> st_r.return_pair_ff)
        else $error("one-shot end did not set pair-ff");
    chk_pair_inc: assert property
        (s_pair_done |=> !st_r.return_pair_ff
            && return_pair_count == $past(return_pair_count) + 4'h1)
        else $error("pair counter did not increment");
    chk_pair_limit: assert property
        (return_pair_count == 4'h5 |-> !st_r.return_pair_ff)
        else $error("pair-ff set at maximum height");

endmodule

/* File: src/gns_pkg.sv */
// shared types and constants for the growing net symbol generator
package gns_pkg;

    // ==========================================================
    // counter widths and fixed values
    localparam int          GNS_CNT_W       = 4;       // net-start counter width
    localparam logic [3:0]  GNS_START_TERM  = 4'hF;    // terminal count of net-start counter
    localparam logic [3:0]  GNS_START_BASE  = 4'h1;    // preset at zero return pairs
    localparam logic [3:0]  GNS_PAIR_MAX    = 4'h5;    // return-pair count that freezes height
    localparam logic [3:0]  GNS_PAIR_ZERO   = 4'h0;    // return-pair count after serve
    localparam logic [3:0]  GNS_SHOT_LEN    = 4'h4;    // return one-shot low time, cycles
    localparam logic [3:0]  GNS_SHOT_IDLE   = 4'h0;    // one-shot idle count

    // ==========================================================
    // beam position bits from the video timing counters
    typedef struct packed {
        logic vert_field_end;   // end of field marker
        logic vert_half_bit;    // low in top half, high in bottom half
        logic vert_dash_bit;    // dash cadence of the net
        logic horiz_half_bit;   // high from screen center onward
        logic horiz_fine_bit;   // fine horizontal clock bit
    } gns_timing_t;

    // play signals from serve and ball logic
    typedef struct packed {
        logic serve;            // high while ball is in play after a serve
        logic ball_motion;      // pulse on a return off a paddle
        logic ball_return;      // pulse on a ball return
    } gns_play_t;

    // net outputs, both active low
    typedef struct packed {
        logic net_video_n;      // dashed net video
        logic net_present_n;    // net presence toward out-of-bounds logic
    } gns_net_out_t;

    // complete block state
    typedef struct packed {
        gns_timing_t   tim_prev;              // last sample of timing bits
        gns_play_t     play_prev;             // last sample of play bits
        logic [3:0]    divider_start_counter; // counts toward net start
        logic          divider_enable_ff;     // net enable, cleared means preset
        logic          return_pair_ff;        // set at one-shot end, cleared by return
        logic [3:0]    return_pair_counter;   // completed return pairs
        logic [3:0]    return_oneshot;        // remaining one-shot cycles
        gns_net_out_t  out;                   // registered outputs
    } gns_state_t;

    // value after reset: outputs inactive high, net held off
    localparam gns_state_t GNS_STATE_RESET = '{
        tim_prev:              5'h00,
        play_prev:             3'h0,
        divider_start_counter: GNS_START_BASE,
        divider_enable_ff:     1'b0,
        return_pair_ff:        1'b0,
        return_pair_counter:   GNS_PAIR_ZERO,
        return_oneshot:        GNS_SHOT_IDLE,
        out:                   2'h3
    };

endpackage

/* File: tb/gns_net_gen_tb.sv */
// self-checking bench for the growing net generator
`timescale 1ns/1ps

module gns_net_gen_tb;
    import gns_pkg::*;

    // ==========================================================
    // signals and bookkeeping
    localparam logic [3:0] SHOT = 4'h3; // short one-shot keeps the run brief
    logic         core_clk;             // 20 MHz video clock
    logic         resetn;               // synchronous reset, active low
    gns_timing_t  timing;               // from the far-side model
    gns_play_t    play;                 // driven here on falling edges
    gns_net_out_t net_out;              // net video and presence
    logic [3:0]   return_pair_count;    // height step seen
    logic [3:0]   h_pos;                // beam column
    logic [8:0]   v_pos;                // beam line
    logic         net_hit;              // boundary flag from the far side
    logic [15:0]  lfsr = 16'hDEED;      // random source, fixed start
    int           n_mismatch = 0;       // failed comparisons
    int           checks_done = 0;      // all comparisons
    int           marks = 0;            // field windows completed
    int           vid_cyc, pres_cyc, first_line, hit_cyc;     // running field counts
    int           snap_vid, snap_pres, snap_first, snap_hit;  // last complete field
    int           t, i, np, ln;         // loop and expectation scratch

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    gns_net_gen #(.SHOT_LEN(SHOT)) gns_net_gen_i (.core_clk(core_clk), .resetn(resetn),
        .timing(timing), .play(play), .net_out(net_out), .return_pair_count(return_pair_count));
    gns_video_model gns_video_model_i (.core_clk(core_clk), .play(play), .net_out(net_out),
        .timing(timing), .h_pos(h_pos), .v_pos(v_pos), .net_hit(net_hit));

    // ==========================================================
    // field monitor: window runs line 64 to line 64, where no net is drawn
    always @(negedge core_clk)
    begin
        if (v_pos == 9'h040 && h_pos == 4'h0)
        begin
            snap_vid = vid_cyc;
            snap_pres = pres_cyc;
            snap_first = first_line;
            snap_hit = hit_cyc;
            hit_cyc = 0;
            marks++;
            vid_cyc = 0;
            pres_cyc = 0;
            first_line = -1;
        end
        else
        begin
            if (net_out.net_video_n === 1'b0)
                vid_cyc++;
            if (net_hit === 1'b1)
                hit_cyc++;
            if (net_out.net_present_n === 1'b0)
            begin
                pres_cyc++;
                if (first_line < 0)
                    first_line = int'(v_pos);
            end
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // bounded wait for whole field windows; a stall ends the run
    task automatic wait_marks(input int n);
        int target;
        target = marks + n;
        for (int k = 0; k < 10000 && marks < target; k++)
            @(negedge core_clk);
        if (marks < target)
        begin
            n_mismatch++;
            $display("BAD field_mark expected %0d seen %0d", target, marks);
            wrap_up();
        end
    endtask

    // one volley pair; the second motion lands while the one-shot is busy
    task automatic do_return;
        lfsr = lfsr_next(lfsr);
        play.ball_motion = 1'b1;
        tick(1);
        play.ball_motion = 1'b0;
        tick(1);
        play.ball_motion = 1'b1;
        tick(1);
        play.ball_motion = 1'b0;
        tick(int'(SHOT) + 3 + int'(lfsr[1:0]));
        play.ball_return = 1'b1;
        tick(1);
        play.ball_return = 1'b0;
        tick(2);
    endtask

    // ==========================================================
    // main sequence: serves with saturating, empty and random volleys
    initial
    begin
        resetn = 1'b0;
        play = '0;
        tick(2);
        resetn = 1'b1;
        for (t = 0; t < 4; t++)
        begin
            lfsr = lfsr_next(lfsr);
            np = (t == 0) ? 7 : (t == 1) ? 0 : int'(lfsr[2:0]);
            play.serve = 1'b0;
            tick(2);
            play.serve = 1'b1;
            tick(2);
            check("pair_count_serve", 16'(return_pair_count), 16'h0000);
            play.ball_return = 1'b1;
            tick(1);
            play.ball_return = 1'b0;
            tick(2);
            check("pair_count_stray", 16'(return_pair_count), 16'h0000);
            for (i = 0; i < np; i++)
            begin
                do_return();
                check("pair_count", 16'(return_pair_count), 16'((i < 5) ? i + 1 : 5));
            end
            // preset 1+2*pairs; 15-preset dash rises from line 132 give the top line
            ln = 132 + 8 * (14 - (1 + 2 * ((np > 5) ? 5 : np)));
            wait_marks(2);
            check("net_top_line", 16'(snap_first), 16'(ln));
            // the top line opens a lit group of four and line 255 closes one
            check("dash_cycles", 16'(snap_vid), 16'((260 - ln) * 4));
            check("presence_cycles", 16'(snap_pres), 16'((256 - ln) * 8));
            // one blanking column per line, plus the rest of each drawn net row
            check("net_hit_cycles", 16'(snap_hit), 16'(256 + (256 - ln) * 7));
        end
        wrap_up();
    end
endmodule

/* File: tb/gns_video_model.sv */
// far-side model: free-running beam position counters and a net-hit boundary flag
`timescale 1ns/1ps

// ==========================================================
// video timing counters, scaled down: 16 clocks a line, 256 lines a field
module gns_video_model
    import gns_pkg::*;
(
    // clock
    input  wire logic         core_clk,
    // observed play and net
    input  wire gns_play_t    play,
    input  wire gns_net_out_t net_out,
    // beam position toward the net block
    output      gns_timing_t  timing,
    // raw counters for the bench
    output      logic [3:0]   h_pos,
    output      logic [8:0]   v_pos,
    // ball stopped by net or blanking
    output      logic         net_hit
);
    logic [3:0] h_r = 4'h0;   // horizontal position, free running
    logic [8:0] v_r = 9'h000; // line number, wraps after 255

    // counters move on the falling edge, away from the sampling edge
    always @(negedge core_clk)
    begin
        h_r <= h_r + 4'h1;
        if (h_r == 4'hF)
            v_r <= (v_r == 9'h0FF) ? 9'h000 : v_r + 9'h001;
    end

    // bit picks: a dash of 4 lines every 8 lines, halves at line 128 and column 8
    assign timing = '{vert_field_end: (v_r == 9'h0FF), vert_half_bit: v_r[7],
                      vert_dash_bit: v_r[2], horiz_half_bit: h_r[3], horiz_fine_bit: h_r[1]};
    assign h_pos = h_r;
    assign v_pos = v_r;
    // the last column stands in for blanking; the net column is a wall too
    assign net_hit = play.serve & (~net_out.net_present_n | (h_r == 4'hF));
endmodule
